// ===== design/dfsi_pkg.sv
package dfsi_pkg;

   // Profile setting codes (0 = inactive)
   localparam logic [3:0] PROFILE_OFF = 4'h0;
   localparam int WORD_W = 16;
   localparam int MAX_WORDS = 6;

   // Word positions in the returned image
   localparam logic [2:0] WORD_STATUS = 3'h0;
   localparam logic [2:0] WORD_SPEED = 3'h1;
   localparam logic [2:0] WORD_INPUTS = 3'h2;
   localparam logic [2:0] WORD_PARAM = 3'h3;
   localparam logic [2:0] WORD_TORQUE = 3'h4;
   localparam logic [2:0] WORD_CURRENT = 3'h5;

   // Status word field positions
   localparam int ST_FAULT_BIT = 15;
   localparam int ST_PID_AUTO_BIT = 14;
   localparam int ST_UNDERVOLT_BIT = 13;
   localparam int ST_REMOTE_BIT = 12;
   localparam int ST_JOG_BIT = 11;
   localparam int ST_CW_BIT = 10;
   localparam int ST_ENABLE_BIT = 9;
   localparam int ST_RUN_BIT = 8;

   // Discrete input byte: input one sits in bit 7 down to input four in bit 4
   localparam int DI_TOP_BIT = 7;
   localparam int DI_COUNT = 4;

   // Speed scaling: 13-bit magnitude plus sign
   localparam logic [15:0] SPEED_FULL_CW = 16'h1FFF;
   localparam logic [15:0] SPEED_FULL_CCW = 16'hE001;

   // Operating-state parameter codes
   localparam logic [15:0] STATE_READY = 16'h0000;
   localparam logic [15:0] STATE_RUN = 16'h0001;
   localparam logic [15:0] STATE_UNDERVOLT = 16'h0002;
   localparam logic [15:0] STATE_FAULT = 16'h0003;

   // Bus parameter fault code range
   localparam logic [7:0] BUS_PARAM_FAULT_FIRST = 8'h18;
   localparam logic [7:0] BUS_PARAM_FAULT_LAST = 8'h1B;

   // Filter time constants in ms and the clock rate
   localparam int CLK_HZ = 50000000;
   localparam int TORQUE_TAU_MS = 500;
   localparam int CURRENT_TAU_MS = 300;
   localparam int TORQUE_TAU_CYC = CLK_HZ / 1000 * TORQUE_TAU_MS;
   localparam int CURRENT_TAU_CYC = CLK_HZ / 1000 * CURRENT_TAU_MS;
   // Filter update period; k = tau / tick, alpha = 1/k
   localparam int FILT_TICK_CYC = 50000;
   localparam int TORQUE_K = TORQUE_TAU_CYC / FILT_TICK_CYC;
   localparam int CURRENT_K = CURRENT_TAU_CYC / FILT_TICK_CYC;

   // Link-loss actions
   typedef enum logic [2:0] {
      DFSI_LOSS_RAMP_STOP,
      DFSI_LOSS_COAST,
      DFSI_LOSS_HOLD,
      DFSI_LOSS_LOCAL,
      DFSI_LOSS_LOCAL_KEEP
   } dfsi_loss_t;

endpackage

// ===== design/dfsi_status_image.sv
`timescale 1ns/10ps
module dfsi_status_image #(
   parameter int TORQUE_K = dfsi_pkg::TORQUE_K,
   parameter int CURRENT_K = dfsi_pkg::CURRENT_K,
   parameter int FILT_TICK_CYC = dfsi_pkg::FILT_TICK_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Settings
   input wire logic [3:0] bus_profile_select,
   input wire logic [1:0] bus_standard,
   input wire logic [1:0] bus_word_count_code,
   input wire logic [2:0] link_loss_action,
   // Link condition
   input wire logic link_lost,
   input wire logic board_off,
   // Drive state
   input wire logic fault_active,
   input wire logic pid_auto,
   input wire logic undervoltage,
   input wire logic remote_mode,
   input wire logic jog_active,
   input wire logic rot_cw,
   input wire logic gen_enable,
   input wire logic running,
   input wire logic [7:0] fault_code,
   // Speed as fraction of synchronous speed, 13-bit magnitude
   input wire logic [12:0] speed_mag,
   // Discrete inputs, one to four
   input wire logic discrete_input_one,
   input wire logic discrete_input_two,
   input wire logic discrete_input_three,
   input wire logic discrete_input_four,
   // Selected parameter, already scaled to full precision
   input wire logic [15:0] param_read_select,
   input wire logic [15:0] param_value,
   input wire logic param_is_state,
   // Raw currents, undotted
   input wire logic [15:0] torque_current_param,
   input wire logic [15:0] motor_current_param,
   // Bus-driven commands before loss handling
   input wire logic bus_start,
   input wire logic bus_enable,
   input wire logic bus_remote,
   input wire logic [15:0] bus_outputs,
   // Image out
   output logic [15:0] image_word [dfsi_pkg::MAX_WORDS],
   output logic [2:0] image_words,
   output logic [15:0] param_select_out,
   // Reaction outputs
   output logic cmd_start,
   output logic cmd_enable,
   output logic cmd_remote,
   output logic cmd_keep_ref,
   output logic [15:0] cmd_outputs
);

   ////////////////////////////////////////////////////////////////////////
   // Profile decode: code 1..3 one standard, 4..6 another, 7..9 a third
   logic [2:0] words_next;
   logic [2:0] words_reg;
   logic [1:0] std_next;
   logic [1:0] std_reg;

   always_comb begin
      words_next = 3'h0;
      std_next = 2'h0;
      if (bus_profile_select != dfsi_pkg::PROFILE_OFF &&
          bus_profile_select <= 4'h9) begin
         std_next = 2'((bus_profile_select - 4'h1) / 4'h3) + 2'h1;
         unique case (4'((bus_profile_select - 4'h1) % 4'h3))
            4'h0: words_next = 3'h2;
            4'h1: words_next = 3'h4;
            default: words_next = 3'h6;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         words_reg <= 3'h0;
         std_reg <= 2'h0;
      end else begin
         words_reg <= words_next;
         std_reg <= std_next;
      end
   end

   assign image_words = words_reg;
   assign param_select_out = param_read_select;

   ////////////////////////////////////////////////////////////////////////
   // Filters: y += (x - y) / k each tick, 16 fractional bits held
   logic [15:0] tick_reg;
   logic [15:0] tick_next;
   logic tick;
   logic [31:0] torq_acc_reg;
   logic [31:0] torq_acc_next;
   logic [31:0] curr_acc_reg;
   logic [31:0] curr_acc_next;

   assign tick = (tick_reg == 16'(FILT_TICK_CYC - 1));

   function automatic logic [31:0] lp_step(input logic [31:0] acc,
                                           input logic [15:0] x,
                                           input int k);
      logic signed [33:0] diff;
      diff = $signed({2'b00, x, 16'h0000}) - $signed({2'b00, acc});
      lp_step = 32'($signed({2'b00, acc}) + diff / k);
   endfunction

   always_comb begin
      tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
      torq_acc_next = torq_acc_reg;
      curr_acc_next = curr_acc_reg;
      if (tick) begin
         torq_acc_next = lp_step(torq_acc_reg, torque_current_param,
                                 TORQUE_K);
         curr_acc_next = lp_step(curr_acc_reg, motor_current_param,
                                 CURRENT_K);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tick_reg <= 16'h0000;
         torq_acc_reg <= 32'h00000000;
         curr_acc_reg <= 32'h00000000;
      end else begin
         tick_reg <= tick_next;
         torq_acc_reg <= torq_acc_next;
         curr_acc_reg <= curr_acc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Image assembly
   logic [15:0] full_next [dfsi_pkg::MAX_WORDS];
   logic [15:0] img_next [dfsi_pkg::MAX_WORDS];
   logic [15:0] img_reg [dfsi_pkg::MAX_WORDS];
   logic [3:0] di_vec;
   logic [15:0] state_code;
   logic bus_fault;

   assign di_vec = {discrete_input_one, discrete_input_two,
                    discrete_input_three, discrete_input_four};
   assign bus_fault = fault_code >= dfsi_pkg::BUS_PARAM_FAULT_FIRST &&
                      fault_code <= dfsi_pkg::BUS_PARAM_FAULT_LAST;

   always_comb begin
      // Fault wins over undervoltage, unless its code is a bus parameter fault (18h..1Bh), since it is the more urgent report
      if (fault_active && !bus_fault) begin
         state_code = dfsi_pkg::STATE_FAULT;
      end else if (undervoltage) begin
         state_code = dfsi_pkg::STATE_UNDERVOLT;
      end else if (running) begin
         state_code = dfsi_pkg::STATE_RUN;
      end else begin
         state_code = dfsi_pkg::STATE_READY;
      end
   end

   always_comb begin
      full_next[dfsi_pkg::WORD_STATUS] = {fault_active, pid_auto,
         undervoltage, remote_mode, jog_active, rot_cw, gen_enable,
         running, fault_code};
      // Two's complement keeps CCW full scale at E001h
      full_next[dfsi_pkg::WORD_SPEED] = rot_cw ? {3'b000, speed_mag} :
         16'(16'h0000 - {3'b000, speed_mag});
      full_next[dfsi_pkg::WORD_INPUTS] = {8'h00, di_vec, 4'h0};
      full_next[dfsi_pkg::WORD_PARAM] = param_is_state ? state_code :
         param_value;
      full_next[dfsi_pkg::WORD_TORQUE] = torq_acc_reg[31:16];
      full_next[dfsi_pkg::WORD_CURRENT] = curr_acc_reg[31:16];
   end

   genvar gi;
   generate
      for (gi = 0; gi < dfsi_pkg::MAX_WORDS; gi++) begin : g_word
         assign img_next[gi] = (3'(gi) < words_reg) ? full_next[gi] :
                               16'h0000;
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               img_reg[gi] <= 16'h0000;
            end else begin
               img_reg[gi] <= img_next[gi];
            end
         end
         assign image_word[gi] = img_reg[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Link-loss reaction
   typedef enum logic [1:0] {
      DFSI_ONLINE,
      DFSI_OFFLINE
   } dfsi_link_t;

   dfsi_link_t link_reg;
   dfsi_link_t link_next;
   logic loss;
   logic start_next, enable_next, remote_next, keep_next;
   logic start_reg, enable_reg, remote_reg, keep_reg;
   logic [15:0] outs_next;
   logic [15:0] outs_reg;

   assign loss = (link_lost || board_off) && std_reg != 2'h0;

   always_comb begin
      link_next = link_reg;
      start_next = bus_start;
      enable_next = bus_enable;
      remote_next = bus_remote;
      keep_next = 1'b0;
      outs_next = bus_outputs;
      unique case (link_reg)
         DFSI_ONLINE: begin
            if (loss) begin
               link_next = DFSI_OFFLINE;
            end
         end
         DFSI_OFFLINE: begin
            start_next = start_reg;
            enable_next = enable_reg;
            remote_next = remote_reg;
            keep_next = keep_reg;
            outs_next = outs_reg;
            if (!loss) begin
               link_next = DFSI_ONLINE;
               outs_next = 16'h0000;
               keep_next = 1'b0;
            end
         end
         default: link_next = DFSI_ONLINE;
      endcase
      if (link_next == DFSI_OFFLINE && link_reg == DFSI_ONLINE) begin
         unique case (link_loss_action)
            3'(dfsi_pkg::DFSI_LOSS_RAMP_STOP): start_next = 1'b0;
            3'(dfsi_pkg::DFSI_LOSS_COAST): enable_next = 1'b0;
            3'(dfsi_pkg::DFSI_LOSS_HOLD): ;
            3'(dfsi_pkg::DFSI_LOSS_LOCAL): remote_next = 1'b0;
            3'(dfsi_pkg::DFSI_LOSS_LOCAL_KEEP): begin
               remote_next = 1'b0;
               keep_next = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         link_reg <= DFSI_ONLINE;
         start_reg <= 1'b0;
         enable_reg <= 1'b0;
         remote_reg <= 1'b0;
         keep_reg <= 1'b0;
         outs_reg <= 16'h0000;
      end else begin
         link_reg <= link_next;
         start_reg <= start_next;
         enable_reg <= enable_next;
         remote_reg <= remote_next;
         keep_reg <= keep_next;
         outs_reg <= outs_next;
      end
   end

   assign cmd_start = start_reg;
   assign cmd_enable = enable_reg;
   assign cmd_remote = remote_reg;
   assign cmd_keep_ref = keep_reg;
   assign cmd_outputs = outs_reg;

   ////////////////////////////////////////////////////////////////////////
   AST_WORDS_SIX: assert property (@(posedge clk_sys)
      disable iff (srst)
      (bus_profile_select == 4'h3) |=> image_words == 3'h6)
      else $error("six-word profile not decoded");
   AST_TRIM: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg == 3'h2) |=> image_word[2] == 16'h0000)
      else $error("word three returned in two-word profile");
   AST_STATUS: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg != 3'h0) |=> image_word[0][7:0] == $past(fault_code) &&
      image_word[0][15] == $past(fault_active))
      else $error("status word mismatch");
   AST_RUNBIT: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg != 3'h0) |=> image_word[0][8] == $past(running))
      else $error("run bit mismatch");
   AST_SPEED: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg != 3'h0 && !rot_cw && speed_mag == 13'h1FFF) |=>
      image_word[1] == dfsi_pkg::SPEED_FULL_CCW)
      else $error("CCW full speed not E001h");
   AST_DI1: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg >= 3'h4) |=> image_word[2][7] ==
      $past(discrete_input_one))
      else $error("input one not in bit 7");
   AST_LOSS0: assert property (@(posedge clk_sys) disable iff (srst)
      (link_reg == DFSI_ONLINE && loss && link_loss_action == 3'h0) |=>
      !cmd_start [*2])
      else $error("ramp stop not applied");
   AST_LOSS3: assert property (@(posedge clk_sys) disable iff (srst)
      (link_reg == DFSI_ONLINE && loss && link_loss_action == 3'h3) |=>
      !cmd_remote)
      else $error("local mode not taken");
   AST_RETURN: assert property (@(posedge clk_sys) disable iff (srst)
      (link_reg == DFSI_OFFLINE && !loss) |=> cmd_outputs == 16'h0000)
      else $error("outputs not reset on return");
   AST_STATE: assert property (@(posedge clk_sys) disable iff (srst)
      (words_reg >= 3'h4 && param_is_state && undervoltage &&
      !fault_active) |=> image_word[3] == 16'h0002)
      else $error("undervoltage state code wrong");

endmodule

// ===== dv/dfsi_master_model.sv
`timescale 1ns/10ps
module dfsi_master_model (
   // Clock
   input wire logic clk_sys,
   // Commands toward the drive
   output logic bus_start,
   output logic bus_enable,
   output logic bus_remote,
   output logic [15:0] bus_outputs,
   output logic [15:0] param_read_select,
   // Image returned by the drive
   input wire logic [15:0] image_word [dfsi_pkg::MAX_WORDS],
   input wire logic [2:0] image_words
);
   initial begin
      bus_start = 1'h0;
      bus_enable = 1'h0;
      bus_remote = 1'h0;
      bus_outputs = 16'h0000;
      param_read_select = 16'h0000;
   end
   // A master only changes its words right after a clock edge
   task automatic send_cmd(input logic s, input logic e, input logic r,
                           input logic [15:0] o);
      @(posedge clk_sys);
      bus_start <= s;
      bus_enable <= e;
      bus_remote <= r;
      bus_outputs <= o;
   endtask
   task automatic select_param(input logic [15:0] n);
      @(posedge clk_sys);
      param_read_select <= n;
   endtask
endmodule

// ===== dv/drive_fieldbus_status_image_bench.sv
`timescale 1ns/10ps
module drive_fieldbus_status_image_bench;
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic [3:0] prof = 4'h0;
   logic [2:0] act = 3'h0;
   // Spare setting inputs, driven to 3 in the profile test to show they leave the image alone
   logic [1:0] spare = 2'h0;
   logic lost = 1'h0, boff = 1'h0, is_st = 1'h0;
   logic [7:0] st = 8'h00, fcode = 8'h00;
   logic [12:0] mag = 13'h0000;
   logic [3:0] di = 4'h0;
   logic [15:0] pval = 16'h0000, tq = 16'h0000, mc = 16'h0000;
   logic bs, be, br, cs, ce, cr, ck;
   logic [15:0] bo, psel, psel_o, co;
   logic [15:0] img [dfsi_pkg::MAX_WORDS];
   logic [2:0] nw;
   int err_total = 0;
   int tests_run = 0;
   always #10 clk_sys = ~clk_sys;
   dfsi_master_model m (.clk_sys(clk_sys), .bus_start(bs), .bus_enable(be),
      .bus_remote(br), .bus_outputs(bo), .param_read_select(psel),
      .image_word(img), .image_words(nw));
   dfsi_status_image #(.TORQUE_K(5), .CURRENT_K(3), .FILT_TICK_CYC(10))
   i_dut (.clk_sys(clk_sys), .srst(srst), .bus_profile_select(prof),
      .bus_standard(spare), .bus_word_count_code(spare),
      .link_loss_action(act), .link_lost(lost), .board_off(boff),
      .fault_active(st[7]), .pid_auto(st[6]), .undervoltage(st[5]),
      .remote_mode(st[4]), .jog_active(st[3]), .rot_cw(st[2]),
      .gen_enable(st[1]), .running(st[0]), .fault_code(fcode),
      .speed_mag(mag), .discrete_input_one(di[3]),
      .discrete_input_two(di[2]), .discrete_input_three(di[1]),
      .discrete_input_four(di[0]), .param_read_select(psel),
      .param_value(pval), .param_is_state(is_st),
      .torque_current_param(tq), .motor_current_param(mc),
      .bus_start(bs), .bus_enable(be), .bus_remote(br), .bus_outputs(bo),
      .image_word(img), .image_words(nw), .param_select_out(psel_o),
      .cmd_start(cs), .cmd_enable(ce), .cmd_remote(cr), .cmd_keep_ref(ck),
      .cmd_outputs(co));
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_profile;
      int p, n;
      // Nonzero content in the status, speed, inputs and current words so that trimming is visible
      st <= 8'h81;
      fcode <= 8'h05;
      mag <= 13'h0100;
      di <= 4'h9;
      mc <= 16'h0384;
      spare <= 2'h3;
      for (p = 0; p < 11; p++) begin
         @(posedge clk_sys);
         prof <= p[3:0];
         tick(3);
         n = (p >= 1 && p <= 9) ? ((p - 1) % 3 + 1) * 2 : 0;
         chk("word count", n, {13'h0, nw});
         chk("status word", (n != 0) ? 16'h8105 : 16'h0000, img[0]);
         chk("speed word", (n != 0) ? 16'hFF00 : 16'h0000, img[1]);
         chk("third word", (n >= 4) ? 16'h0090 : 16'h0000, img[2]);
         chk("top word", (n == 6), (img[5] != 16'h0000));
      end
      // Let the current filter drain before its own test
      @(posedge clk_sys);
      mc <= 16'h0000;
      $display("Test profile done");
   endtask
   task automatic t_status;
      int i;
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         prof <= 4'h3;
         st <= 8'h01 << i;
         fcode <= i[0] ? 8'hE7 : 8'h18;
         tick(3);
         chk("status", {st, fcode}, img[dfsi_pkg::WORD_STATUS]);
      end
      @(posedge clk_sys);
      st <= 8'h1F;
      tick(3);
      chk("status low", 16'h1FE7, img[0]);
      $display("Test status done");
   endtask
   task automatic t_speed_inputs;
      int i;
      logic [15:0] exp [4] = '{16'h1FFF, 16'hE001, 16'h1000, 16'hF000};
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         st <= i[0] ? 8'h00 : 8'h04;
         mag <= (i < 2) ? 13'h1FFF : 13'h1000;
         di <= 4'h1 << i;
         tick(3);
         chk("speed", exp[i], img[dfsi_pkg::WORD_SPEED]);
         chk("inputs", {8'h00, 4'h1 << i, 4'h0}, img[2]);
      end
      $display("Test speed done");
   endtask
   task automatic t_param;
      m.select_param(16'h0065);
      @(posedge clk_sys);
      pval <= 16'h0514;
      is_st <= 1'h0;
      tick(3);
      chk("select echo", 16'h0065, psel_o);
      chk("param", 16'h0514, img[dfsi_pkg::WORD_PARAM]);
      @(posedge clk_sys);
      is_st <= 1'h1;
      st <= 8'h00;
      tick(3);
      chk("state ready", dfsi_pkg::STATE_READY, img[3]);
      @(posedge clk_sys);
      st <= 8'h01;
      tick(3);
      chk("state run", dfsi_pkg::STATE_RUN, img[3]);
      @(posedge clk_sys);
      st <= 8'h21;
      tick(3);
      chk("state uv", dfsi_pkg::STATE_UNDERVOLT, img[3]);
      @(posedge clk_sys);
      st <= 8'hA1;
      fcode <= 8'h05;
      tick(3);
      chk("state fault", dfsi_pkg::STATE_FAULT, img[3]);
      $display("Test param done");
   endtask
   task automatic t_loss;
      int a;
      for (a = 0; a < 5; a++) begin
         m.send_cmd(1'h1, 1'h1, 1'h1, 16'h001F);
         @(posedge clk_sys);
         act <= a[2:0];
         lost <= 1'h0;
         boff <= 1'h0;
         tick(3);
         chk("online outs", 16'h001F, co);
         @(posedge clk_sys);
         lost <= (a != 2);
         boff <= (a == 2);
         tick(3);
         chk("loss start", (a == 0) ? 16'h0 : 16'h1, cs);
         chk("loss enable", (a == 1) ? 16'h0 : 16'h1, ce);
         chk("loss remote", (a >= 3) ? 16'h0 : 16'h1, cr);
         chk("loss keep", (a == 4) ? 16'h1 : 16'h0, ck);
         @(posedge clk_sys);
         lost <= 1'h0;
         boff <= 1'h0;
         tick(1);
         chk("back online outs", 16'h0000, co);
      end
      $display("Test loss done");
   endtask
   task automatic t_filter;
      logic [15:0] t, c;
      @(posedge clk_sys);
      tq <= 16'h03E8;
      mc <= 16'h0384;
      tick(16);
      t = img[dfsi_pkg::WORD_TORQUE];
      c = img[dfsi_pkg::WORD_CURRENT];
      chk("torque rising", 16'h1, (t > 0 && t < 16'h03E8));
      chk("faster current", 16'h1, (t * 900 < c * 1000));
      tick(800);
      chk("torque settle", 16'h1, (img[4] >= 995 && img[4] <= 1000));
      chk("current settle", 16'h1, (img[5] >= 897 && img[5] <= 900));
      $display("Test filter done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      tick(11);
      chk("reset count", 16'h0000, {13'h0, nw});
      chk("reset word", 16'h0000, img[0]);
      chk("reset start", 16'h0000, cs);
      @(posedge clk_sys);
      srst <= 1'h0;
      t_profile();
      t_status();
      t_speed_inputs();
      t_param();
      t_loss();
      t_filter();
      give_verdict();
   end
   // Whole run needs about 1000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end
endmodule
